//--- bench/frss_master.sv
// Fieldbus master model: writes and reads drive objects of the stop sequencer.
// Assumes the object port samples on the rising edge of clk.
`timescale 1ns/1ps
module frss_master
(
    input  wire logic        clk,
    output logic             obj_wr,
    output logic      [15:0] obj_index,
    output logic      [31:0] obj_wdata,
    input  wire logic [31:0] obj_rdata
);
    initial
    begin
        obj_wr    = 1'b0;
        obj_index = 16'h0000;
        obj_wdata = 32'h0000_0000;
    end
    // Data is inverted after the strobe so nothing can lean on stale bits
    task automatic write_obj(input logic [15:0] idx, input logic [31:0] val);
        @(posedge clk);
        obj_wr    <= 1'b1;
        obj_index <= idx;
        obj_wdata <= val;
        @(posedge clk);
        obj_wr    <= 1'b0;
        obj_wdata <= ~val;
    endtask : write_obj
    // Readback is registered: value taken two edges after the index
    task automatic read_obj(input logic [15:0] idx, output logic [31:0] val);
        @(posedge clk);
        obj_index <= idx;
        @(posedge clk);
        @(posedge clk);
        val = obj_rdata;
    endtask : read_obj
endmodule : frss_master

//--- bench/test_fault_reaction_stop_sequencer.sv
// Testbench of the fault reaction stop sequencer.
// Assumes frss_master as the object writer and the design in core/.
`timescale 1ns/1ps
module test_fault_reaction_stop_sequencer
    import frss_pkg::*;
;
    logic        clk = 1'b0, reset_n, alarm_valid, halt_bit, fault_reset, obj_wr, prev_act = 1'b0;
    logic [15:0] obj_index, actual_rpm;
    logic [31:0] obj_wdata, obj_rdata, rd;
    logic [7:0]  op_mode;
    frss_alarm_s alarm_code;
    frss_state_e drive_state;
    frss_stop_s  stop_cmd;
    frss_stop_s  exp_q[$];
    frss_stop_s  exp_s;
    logic [31:0] val[6];
    logic [15:0] idx[6] = '{16'h3510, 16'h605E, 16'h6084, 16'h6085, 16'h6087, 16'h609A};
    logic [7:0]  modes[8] = '{8'h01, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A};
    int          errors = 0, num_checks = 0;
    integer      seed = 32'h5d2237ad;

    always #25 clk = ~clk;

    frss_master u_frss_master (.clk(clk), .obj_wr(obj_wr), .obj_index(obj_index), .obj_wdata(obj_wdata),
                               .obj_rdata(obj_rdata));
    frss_top u_frss_top (.clk(clk), .reset_n(reset_n), .obj_wr(obj_wr), .obj_index(obj_index),
                         .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .alarm_valid(alarm_valid),
                         .alarm_code(alarm_code), .op_mode(op_mode), .actual_rpm(actual_rpm),
                         .halt_bit(halt_bit), .fault_reset(fault_reset), .drive_state(drive_state),
                         .stop_cmd(stop_cmd));

    task automatic complete_run();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_state(input frss_state_e got, input frss_state_e exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_state

    task automatic chk_stop(input frss_stop_s got, input frss_stop_s exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_stop

    // Source and rate worked out independently of the design
    function automatic frss_stop_s expect_stop(input logic [7:0] g, input logic [3:0] s,
                                               input logic [7:0] m, input logic [15:0] sel);
        frss_stop_s e;
        e = '{1'b1, FRSS_SRC_ALARM_SEQ, 32'h0000_0000, val[0][15:0]};
        if ((g == 8'h50 || g == 8'h51 || g == 8'h55 || g == 8'h58) && s <= 4'h7 && sel != 16'h0000)
            case (m)
                8'h01, 8'h03, 8'h07, 8'h08, 8'h09: e.source = (sel == 16'h0001) ? FRSS_SRC_PROFILE : FRSS_SRC_QSTOP;
                8'h06:                             e.source = (sel == 16'h0001) ? FRSS_SRC_HOMING : FRSS_SRC_QSTOP;
                8'h04, 8'h0A:                      e.source = FRSS_SRC_TORQUE;
                default:                           ;
            endcase
        case (e.source)
            FRSS_SRC_PROFILE: e.rate = val[2];
            FRSS_SRC_QSTOP:   e.rate = val[3];
            FRSS_SRC_TORQUE:  e.rate = val[4];
            FRSS_SRC_HOMING:  e.rate = val[5];
            default:          ;
        endcase
        return e;
    endfunction : expect_stop

    // Bounded wait; a timeout shows up as a failed compare
    task automatic wait_state(input frss_state_e s);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (drive_state !== s && n < 50);
        chk_state(drive_state, s);
        if (drive_state !== s)
            complete_run();
    endtask : wait_state

    task automatic run_alarm(input logic [7:0] g, input logic [3:0] s, input logic [7:0] m, input logic [15:0] sel);
        u_frss_master.write_obj(16'h605E, {16'h0000, sel});
        @(posedge clk);
        op_mode     <= m;
        actual_rpm  <= 16'h03E8;
        alarm_code  <= '{g, s};
        alarm_valid <= 1'b1;
        exp_q.push_back(expect_stop(g, s, m, sel));
        @(posedge clk);
        // A second, different alarm while reacting must be ignored
        alarm_code  <= '{8'h26, 4'h0};
        op_mode     <= m ^ 8'h0F;
        wait_state(FRSS_FAULT_REACT);
        alarm_valid <= 1'b0;
        actual_rpm  <= 16'h001F;
        repeat (2) @(posedge clk);
        chk_val({31'h0, stop_cmd.active}, 32'h1);
        chk_state(drive_state, FRSS_FAULT_REACT);
        actual_rpm  <= 16'h001E;
        wait_state(FRSS_FAULT);
        chk_val({31'h0, stop_cmd.active}, 32'h0);
        fault_reset <= 1'b1;
        @(posedge clk);
        fault_reset <= 1'b0;
        wait_state(FRSS_OP_ENABLED);
    endtask : run_alarm

    // Monitor: each new stop command takes the oldest expectation
    always @(posedge clk)
    begin
        prev_act <= stop_cmd.active;
        if (reset_n === 1'b1 && stop_cmd.active === 1'b1 && prev_act === 1'b0)
        begin
            exp_s = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
            chk_stop(stop_cmd, exp_s);
        end
    end

    initial
    begin
        reset_n     = 1'b0;
        alarm_valid = 1'b0;
        alarm_code  = '0;
        op_mode     = 8'h01;
        actual_rpm  = 16'h0000;
        halt_bit    = 1'b0;
        fault_reset = 1'b0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            u_frss_master.read_obj(idx[i], rd);
            chk_val(rd, 32'h0);
            val[i] = (i < 2) ? 32'h2 & $random(seed) | 32'h2 : $random(seed);
        end
        val[0] = $random(seed) & 32'h7;
        for (int i = 0; i < 6; i++)
            u_frss_master.write_obj(idx[i], val[i]);
        for (int i = 0; i < 6; i++)
        begin
            u_frss_master.read_obj(idx[i], rd);
            chk_val(rd, (i < 2) ? val[i] & 32'hFFFF : val[i]);
        end
        u_frss_master.write_obj(16'h1234, 32'hFFFF_FFFF);
        u_frss_master.read_obj(16'h1234, rd);
        chk_val(rd, 32'h0);
        u_frss_master.write_obj(16'h605E, 32'h3);
        u_frss_master.write_obj(16'h605E, 32'hFFFF);
        u_frss_master.read_obj(16'h605E, rd);
        chk_val(rd, 32'h2);
        $display("test objects done");
        for (int s = 0; s < 3; s++)
            for (int m = 0; m < 8; m++)
                run_alarm(8'h55, 4'($random(seed) & 7), modes[m], 16'(s));
        run_alarm(8'h50, 4'h7, 8'h06, 16'h2);
        run_alarm(8'h51, 4'h0, 8'h0A, 16'h1);
        run_alarm(8'h58, 4'h3, 8'h09, 16'h1);
        run_alarm(8'h26, 4'h0, 8'h01, 16'h2);
        run_alarm(8'h55, 4'h8, 8'h01, 16'h1);
        run_alarm(8'h55, 4'h2, 8'h02, 16'h1);
        $display("test alarms done");
        actual_rpm <= 16'h01F4;
        halt_bit   <= 1'b1;
        op_mode    <= 8'h01;
        exp_q.push_back('{1'b1, FRSS_SRC_PROFILE, val[2], val[0][15:0]});
        repeat (6) @(posedge clk);
        chk_state(drive_state, FRSS_OP_ENABLED);
        actual_rpm <= 16'h001E;
        repeat (4) @(posedge clk);
        chk_state(drive_state, FRSS_OP_ENABLED);
        chk_val({31'h0, stop_cmd.active}, 32'h0);
        halt_bit   <= 1'b0;
        repeat (4) @(posedge clk);
        chk_val(32'(exp_q.size()), 32'h0);
        $display("test halt done");
        complete_run();
    end
endmodule : test_fault_reaction_stop_sequencer

//--- core/frss_map.svh
// Object indices, value codes and limits of the fault reaction stop sequencer.
// Assumes inclusion by core/frss_top.sv only; core/frss_pkg.sv does not include it.
`ifndef FRSS_MAP_SVH
`define FRSS_MAP_SVH

// ****************************************
// Object indices
// ****************************************
`define FRSS_IDX_ALARM_SEQ     16'h3510
`define FRSS_IDX_FAULT_SEL     16'h605E
`define FRSS_IDX_PROFILE_DEC   16'h6084
`define FRSS_IDX_QSTOP_DEC     16'h6085
`define FRSS_IDX_TORQUE_RAMP   16'h6087
`define FRSS_IDX_HOMING_ACC    16'h609A

// ****************************************
// Reset values
// ****************************************
`define FRSS_RST_16            16'h0000
`define FRSS_RST_32            32'h0000_0000

// ****************************************
// Fault reaction selection codes
// ****************************************
`define FRSS_SEL_ALARM         16'h0000
`define FRSS_SEL_RATE_A        16'h0001
`define FRSS_SEL_RATE_B        16'h0002

// ****************************************
// Operation mode codes
// ****************************************
`define FRSS_MODE_PP           8'h01
`define FRSS_MODE_PV           8'h03
`define FRSS_MODE_TQ           8'h04
`define FRSS_MODE_HM           8'h06
`define FRSS_MODE_IP           8'h07
`define FRSS_MODE_CSP          8'h08
`define FRSS_MODE_CSV          8'h09
`define FRSS_MODE_CST          8'h0A

// ****************************************
// Communication alarm groups, sub-code limit
// ****************************************
`define FRSS_GRP_A             8'h50
`define FRSS_GRP_B             8'h51
`define FRSS_GRP_C             8'h55
`define FRSS_GRP_D             8'h58
`define FRSS_SUB_MAX           4'h7

// ****************************************
// Standstill threshold in r/min
// ****************************************
`define FRSS_STOP_RPM          16'h001E

`endif

//--- core/frss_pkg.sv
// Types shared by the fault reaction stop sequencer.
// Assumes the constants of frss_map.svh.
package frss_pkg;

    typedef enum logic [1:0]
    {
        FRSS_OP_ENABLED,
        FRSS_FAULT_REACT,
        FRSS_FAULT
    } frss_state_e;

    typedef enum logic [2:0]
    {
        FRSS_SRC_NONE,
        FRSS_SRC_ALARM_SEQ,
        FRSS_SRC_PROFILE,
        FRSS_SRC_QSTOP,
        FRSS_SRC_HOMING,
        FRSS_SRC_TORQUE
    } frss_src_e;

    typedef struct packed
    {
        logic [7:0] group;
        logic [3:0] sub;
    } frss_alarm_s;

    typedef struct packed
    {
        logic        active;
        frss_src_e   source;
        logic [31:0] rate;
        logic [15:0] alarm_seq;
    } frss_stop_s;

endpackage : frss_pkg

//--- core/frss_top.sv
// Fault reaction stop sequencer: picks the deceleration after an alarm and steps the drive state.
// Assumes every input comes from logic on clk; objects are written by an object port on clk.
//
// Overview of operation
// [RL1] Only selection values 0 to 2 accepted
// [RL2] Selection applies to communication alarm groups only
// [RL3] Selection 0 uses alarm stop sequence
// [RL4] Selection 1 position/velocity uses profile deceleration
// [RL5] Selection 2 position/velocity/homing uses quick stop
// [RL6] Selection 1 homing uses homing acceleration
// [RL7] Selection 1/2 torque modes use torque slope
// [RL8] Other alarms always use alarm stop sequence
// [RL9] Deceleration starts as soon as alarm occurs
// [RL10] State is fault reaction active while decelerating
// [RL11] Stopped when velocity at most 30 r/min
// [RL12] After stop, state becomes Fault
// [RL13] Mode and selection latched at alarm
// [RL14] Halt rising edge decelerates, stays operation enabled
`timescale 1ns/1ps
`include "frss_map.svh"

module frss_top
    import frss_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        obj_wr,
    input  wire logic [15:0] obj_index,
    input  wire logic [31:0] obj_wdata,
    output logic      [31:0] obj_rdata,
    input  wire logic        alarm_valid,
    input  wire frss_alarm_s alarm_code,
    input  wire logic [7:0]  op_mode,
    input  wire logic [15:0] actual_rpm,
    input  wire logic        halt_bit,
    input  wire logic        fault_reset,
    output frss_state_e      drive_state,
    output frss_stop_s       stop_cmd
);

    // ****************************************
    // Objects
    // ****************************************
    logic [15:0] alarm_stop_sequence_select;
    logic [15:0] fault_reaction_select;
    logic [31:0] profile_decel_rate;
    logic [31:0] quick_stop_decel_rate;
    logic [31:0] torque_ramp_rate;
    logic [31:0] homing_accel_rate;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            alarm_stop_sequence_select <= `FRSS_RST_16;
            fault_reaction_select      <= `FRSS_RST_16;
            profile_decel_rate         <= `FRSS_RST_32;
            quick_stop_decel_rate      <= `FRSS_RST_32;
            torque_ramp_rate           <= `FRSS_RST_32;
            homing_accel_rate          <= `FRSS_RST_32;
        end
        else if (obj_wr)
        begin
            unique case (obj_index)
                `FRSS_IDX_ALARM_SEQ:   alarm_stop_sequence_select <= obj_wdata[15:0];
                // Out-of-range values keep the previous setting
                `FRSS_IDX_FAULT_SEL:
                    if (obj_wdata[15:0] <= `FRSS_SEL_RATE_B)
                        fault_reaction_select <= obj_wdata[15:0]; // [RL1]
                `FRSS_IDX_PROFILE_DEC: profile_decel_rate    <= obj_wdata;
                `FRSS_IDX_QSTOP_DEC:   quick_stop_decel_rate <= obj_wdata;
                `FRSS_IDX_TORQUE_RAMP: torque_ramp_rate      <= obj_wdata;
                `FRSS_IDX_HOMING_ACC:  homing_accel_rate     <= obj_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            obj_rdata <= `FRSS_RST_32;
        else
        begin
            unique case (obj_index)
                `FRSS_IDX_ALARM_SEQ:   obj_rdata <= {16'h0000, alarm_stop_sequence_select};
                `FRSS_IDX_FAULT_SEL:   obj_rdata <= {16'h0000, fault_reaction_select};
                `FRSS_IDX_PROFILE_DEC: obj_rdata <= profile_decel_rate;
                `FRSS_IDX_QSTOP_DEC:   obj_rdata <= quick_stop_decel_rate;
                `FRSS_IDX_TORQUE_RAMP: obj_rdata <= torque_ramp_rate;
                `FRSS_IDX_HOMING_ACC:  obj_rdata <= homing_accel_rate;
                default:               obj_rdata <= `FRSS_RST_32;
            endcase
        end
    end

    // ****************************************
    // Alarm capture
    // ****************************************
    logic        comm_alarm;
    logic        stopped;
    logic        alarm_take;
    logic        lat_comm;
    logic [7:0]  lat_mode;
    logic [15:0] lat_sel;

    assign comm_alarm = (alarm_code.group == `FRSS_GRP_A || alarm_code.group == `FRSS_GRP_B ||
                         alarm_code.group == `FRSS_GRP_C || alarm_code.group == `FRSS_GRP_D) &&
                        (alarm_code.sub <= `FRSS_SUB_MAX); // [RL2]
    assign stopped    = (actual_rpm <= `FRSS_STOP_RPM); // [RL11]
    // A second alarm during the reaction does not restart it
    assign alarm_take = alarm_valid && (drive_state == FRSS_OP_ENABLED);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lat_comm <= 1'b0;
            lat_mode <= 8'h00;
            lat_sel  <= `FRSS_RST_16;
        end
        else if (alarm_take)
        begin
            lat_comm <= comm_alarm; // [RL13]
            lat_mode <= op_mode; // [RL13]
            lat_sel  <= fault_reaction_select; // [RL13]
        end
    end

    // ****************************************
    // Deceleration source selection
    // ****************************************
    function automatic frss_src_e pick_src(input logic comm, input logic [7:0] mode, input logic [15:0] sel);
        frss_src_e src;
        src = FRSS_SRC_ALARM_SEQ;
        if (comm && sel != `FRSS_SEL_ALARM) // [RL3] [RL8]
        begin
            unique case (mode)
                `FRSS_MODE_PP, `FRSS_MODE_CSP, `FRSS_MODE_IP, `FRSS_MODE_CSV, `FRSS_MODE_PV:
                    src = (sel == `FRSS_SEL_RATE_A) ? FRSS_SRC_PROFILE : FRSS_SRC_QSTOP; // [RL4] [RL5]
                `FRSS_MODE_HM:
                    src = (sel == `FRSS_SEL_RATE_A) ? FRSS_SRC_HOMING : FRSS_SRC_QSTOP; // [RL6] [RL5]
                `FRSS_MODE_CST, `FRSS_MODE_TQ:
                    src = FRSS_SRC_TORQUE; // [RL7]
                // Unknown modes fall back to the alarm stop sequence
                default: src = FRSS_SRC_ALARM_SEQ;
            endcase
        end
        return src;
    endfunction : pick_src

    frss_src_e fault_src;
    frss_src_e next_src;

    assign fault_src = pick_src(lat_comm, lat_mode, lat_sel);

    // ****************************************
    // Drive state
    // ****************************************
    logic halt_prev;
    logic halting;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            drive_state <= FRSS_OP_ENABLED;
        else
        begin
            unique case (drive_state)
                FRSS_OP_ENABLED:
                    if (alarm_take)
                        drive_state <= FRSS_FAULT_REACT; // [RL9] [RL10]
                FRSS_FAULT_REACT:
                    if (stopped)
                        drive_state <= FRSS_FAULT; // [RL12]
                FRSS_FAULT:
                    if (fault_reset)
                        drive_state <= FRSS_OP_ENABLED;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            halt_prev <= 1'b0;
        else
            halt_prev <= halt_bit;
    end

    // Halt never changes the drive state; an alarm overrides it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            halting <= 1'b0;
        else if (drive_state != FRSS_OP_ENABLED || alarm_take || !halt_bit)
            halting <= 1'b0;
        else if (halt_bit && !halt_prev)
            halting <= 1'b1; // [RL14]
        else if (stopped)
            halting <= 1'b0; // [RL14]
    end

    // ****************************************
    // Stop command output
    // ****************************************
    always_comb
    begin
        next_src = FRSS_SRC_NONE;
        if (drive_state == FRSS_FAULT_REACT && !stopped)
            next_src = fault_src;
        else if (halting && !stopped)
            next_src = FRSS_SRC_PROFILE; // [RL14]
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            stop_cmd <= '0;
        else
        begin
            stop_cmd.active    <= (next_src != FRSS_SRC_NONE);
            stop_cmd.source    <= next_src;
            stop_cmd.alarm_seq <= alarm_stop_sequence_select;
            unique case (next_src)
                FRSS_SRC_PROFILE: stop_cmd.rate <= profile_decel_rate;
                FRSS_SRC_QSTOP:   stop_cmd.rate <= quick_stop_decel_rate;
                FRSS_SRC_HOMING:  stop_cmd.rate <= homing_accel_rate;
                FRSS_SRC_TORQUE:  stop_cmd.rate <= torque_ramp_rate;
                default:          stop_cmd.rate <= `FRSS_RST_32;
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_alarm_taken;
        drive_state == FRSS_OP_ENABLED && alarm_valid;
    endsequence

    sequence s_react_running;
        drive_state == FRSS_FAULT_REACT && !stopped;
    endsequence

    AST_SEL_RANGE: assert property (@(posedge clk) disable iff (!reset_n) // [RL1]
        fault_reaction_select <= `FRSS_SEL_RATE_B)
        else $error("selection out of range");

    AST_NON_COMM: assert property (@(posedge clk) disable iff (!reset_n) // [RL8]
        (s_react_running ##0 !lat_comm) |=> stop_cmd.source == FRSS_SRC_ALARM_SEQ)
        else $error("non-communication alarm not on alarm sequence");

    AST_SEL0: assert property (@(posedge clk) disable iff (!reset_n) // [RL3]
        (s_react_running ##0 lat_sel == `FRSS_SEL_ALARM) |=> stop_cmd.source == FRSS_SRC_ALARM_SEQ)
        else $error("selection 0 not on alarm sequence");

    AST_QSTOP: assert property (@(posedge clk) disable iff (!reset_n) // [RL5]
        (s_react_running ##0 lat_comm && lat_sel == `FRSS_SEL_RATE_B && lat_mode == `FRSS_MODE_HM)
        |=> stop_cmd.source == FRSS_SRC_QSTOP && stop_cmd.rate == $past(quick_stop_decel_rate))
        else $error("quick stop rate not applied");

    AST_TORQUE: assert property (@(posedge clk) disable iff (!reset_n) // [RL7]
        (s_react_running ##0 lat_comm && lat_sel != `FRSS_SEL_ALARM && lat_mode == `FRSS_MODE_CST)
        |=> stop_cmd.source == FRSS_SRC_TORQUE)
        else $error("torque slope not applied");

    AST_ALARM_START: assert property (@(posedge clk) disable iff (!reset_n) // [RL9]
        (s_alarm_taken ##0 actual_rpm > `FRSS_STOP_RPM ##1 !stopped) |=> stop_cmd.active)
        else $error("deceleration did not start");

    AST_REACT_HOLD: assert property (@(posedge clk) disable iff (!reset_n) // [RL10]
        s_react_running |=> drive_state == FRSS_FAULT_REACT)
        else $error("left fault reaction before stop");

    AST_FAULT: assert property (@(posedge clk) disable iff (!reset_n) // [RL12]
        (drive_state == FRSS_FAULT_REACT && stopped) |=> drive_state == FRSS_FAULT && !stop_cmd.active)
        else $error("fault not entered after stop");

    // Looks one cycle behind the state so the capture edge itself is not counted as a change
    AST_LATCH: assert property (@(posedge clk) disable iff (!reset_n) // [RL13]
        $past(drive_state) == FRSS_FAULT_REACT |-> $stable(lat_sel) && $stable(lat_mode) && $stable(lat_comm))
        else $error("latched values changed");

    AST_HALT: assert property (@(posedge clk) disable iff (!reset_n) // [RL14]
        halting |-> drive_state == FRSS_OP_ENABLED)
        else $error("halt left operation enabled");

    AST_HALT_RUN: assert property (@(posedge clk) disable iff (!reset_n) // [RL14]
        (halting && !stopped) |=> stop_cmd.active && stop_cmd.source == FRSS_SRC_PROFILE)
        else $error("halt deceleration not applied");

endmodule : frss_top
